//--- src/belc_defs.svh
`ifndef BELC_DEFS_SVH
`define BELC_DEFS_SVH

// Register byte offsets on the APB slave
`define BELC_OFF_CMD        12'h000
`define BELC_OFF_PSTS       12'h004
`define BELC_OFF_BCTL       12'h008
`define BELC_OFF_SSTS       12'h00C
`define BELC_OFF_EVDIS      12'h010
`define BELC_OFF_CAUSE      12'h014
`define BELC_OFF_LOCK       12'h018

// Command register fields
`define BELC_CMD_PERR_RESP  1
`define BELC_CMD_SERR_EN    8
// Primary status register fields
`define BELC_PSTS_SIG_SERR  30
// Bridge control register fields
`define BELC_BCTL_PERR_RESP 0
`define BELC_BCTL_SERR_FWD  1
`define BELC_BCTL_MA_MODE   5
`define BELC_BCTL_MTO_SERR  11
// Secondary status register fields
`define BELC_SSTS_RCV_SERR  30

// Cause and disable bit positions, one per system-error event
`define BELC_EV_PW_PERR     0
`define BELC_EV_PW_TABORT   1
`define BELC_EV_PW_MABORT   2
`define BELC_EV_PW_DISCARD  3
`define BELC_EV_DW_DISCARD  4
`define BELC_EV_DR_GIVEUP   5
`define BELC_EV_MTIMEOUT    6
`define BELC_EV_SEC_SERR    7
`define BELC_EV_COUNT       8

// Reset values
`define BELC_RST_CMD        16'h0000
`define BELC_RST_BCTL       16'h0000
`define BELC_RST_EVDIS      8'h00

// Retry threshold before discard
`define BELC_RETRY_LIMIT    16777216

// Memory read command code
`define BELC_CMD_MEM_READ   4'h6

`endif

//--- src/belc_pkg.sv
`default_nettype none
package belc_pkg;
    typedef enum logic [2:0] {
        BELC_LK_IDLE   = 3'b000,
        BELC_LK_QUEUED = 3'b001,
        BELC_LK_WAIT   = 3'b010,
        BELC_LK_ISSUE  = 3'b011,
        BELC_LK_HOLD   = 3'b100,
        BELC_LK_ABORT  = 3'b101,
        BELC_LK_LOCKED = 3'b110
    } belc_lock_state_t;

    typedef enum logic [1:0] {
        BELC_ENT_POSTED  = 2'b00,
        BELC_ENT_DWRITE  = 2'b01,
        BELC_ENT_DREAD   = 2'b10
    } belc_entry_kind_t;
endpackage
`default_nettype wire

//--- src/belc_error_lock.sv
`include "belc_defs.svh"
`default_nettype none
module belc_error_lock
    import belc_pkg::*;
#(
    parameter int ENTRIES     = 4,
    parameter int RETRY_LIMIT = `BELC_RETRY_LIMIT
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               sec_data_parity_err,
    input  wire logic               sec_target_write,
    input  wire logic               sec_initiator_read,
    input  wire logic               up_dwrite_completion,
    input  wire logic               primary_parity_error_n,
    input  wire logic               pw_parity_reported,
    input  wire logic               pw_parity_self_detected,
    input  wire logic               pw_target_abort,
    input  wire logic               pw_master_abort,
    input  wire logic               dt_master_timeout,
    input  wire logic               secondary_system_error_in_n,
    input  wire logic [ENTRIES-1:0] entry_retry,
    input  wire logic [ENTRIES-1:0] entry_done,
    input  wire logic [2*ENTRIES-1:0] entry_kind,
    output logic [ENTRIES-1:0]      entry_discard,
    output logic                    secondary_parity_error_n_o,
    output logic                    secondary_parity_error_oe_n,
    output logic                    primary_system_error_n_o,
    output logic                    primary_system_error_oe_n,
    input  wire logic               lk_first,
    input  wire logic               lk_upstream,
    input  wire logic [3:0]         lk_cmd,
    input  wire logic               sec_lock_other,
    input  wire logic               sec_lock_in_n,
    input  wire logic               sec_bus_idle,
    input  wire logic               prior_queue_empty,
    input  wire logic               sec_read_ok,
    input  wire logic               sec_read_tabort,
    input  wire logic               sec_read_mabort,
    input  wire logic               pri_repeat_match,
    input  wire logic               lk_master_timeout,
    input  wire logic               lk_release,
    output logic                    lk_retry,
    output logic                    lk_master_abort,
    output logic                    lk_queue,
    output logic                    lk_sec_request,
    output logic                    sec_lock_out_n,
    output logic                    lk_return_data,
    output logic                    lk_return_tabort,
    output logic                    lk_return_mabort,
    output logic                    lk_cross_retry,
    output logic                    lk_no_prefetch,
    output logic                    lk_forward_locked,
    output logic                    lk_upstream_pass
);
    localparam int CW = $clog2(RETRY_LIMIT) + 1;
    localparam logic [CW-1:0] LAST_RETRY = CW'(RETRY_LIMIT - 1);
    typedef struct packed {
        logic [15:0]                 cmd;
        logic [15:0]                 bctl;
        logic [`BELC_EV_COUNT-1:0]   evdis;
        logic [`BELC_EV_COUNT-1:0]   cause;
        logic                        sig_serr;
        logic                        rcv_serr;
        logic [31:0]                 rdata;
        logic                        sperr;
        logic                        pserr;
        logic [ENTRIES-1:0]          discard;
        logic [ENTRIES-1:0][CW-1:0]  cnt;
        belc_lock_state_t            lk;
        logic                        lk_aborted_ma;
        logic                        sec_lock_drv;
        logic                        retry;
        logic                        mabort;
        logic                        queue;
        logic                        sec_req;
        logic                        ret_data;
        logic                        ret_ta;
        logic                        ret_ma;
        logic                        up_pass;
    } belc_state_t;
    belc_state_t st_reg;
    belc_state_t st_next;
    // Register address decode, shared by the write accept and the error answer
    function automatic logic addr_mapped(input logic [11:0] a);
        addr_mapped = (a == `BELC_OFF_CMD)   || (a == `BELC_OFF_PSTS)  ||
                      (a == `BELC_OFF_BCTL)  || (a == `BELC_OFF_SSTS)  ||
                      (a == `BELC_OFF_EVDIS) || (a == `BELC_OFF_CAUSE) ||
                      (a == `BELC_OFF_LOCK);
    endfunction
    logic         wr_acc;
    logic         rd_setup;
    logic         serr_en;
    logic         perr_pri;
    logic         perr_sec;
    logic [`BELC_EV_COUNT-1:0] ev_raw;
    logic [`BELC_EV_COUNT-1:0] ev_gate;
    logic         serr_fire;
    logic [ENTRIES-1:0] hit_limit;
    logic         lk_timeout_ev;
    logic [31:0]  rd_val;
    assign wr_acc   = psel && penable && pwrite && addr_mapped(paddr);
    assign rd_setup = psel && !penable && !pwrite;
    assign serr_en  = st_reg.cmd[`BELC_CMD_SERR_EN];
    assign perr_pri = st_reg.cmd[`BELC_CMD_PERR_RESP];
    assign perr_sec = st_reg.bctl[`BELC_BCTL_PERR_RESP];
    // Zero wait states: read data is captured during the setup phase
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_mapped(paddr);
    assign prdata  = st_reg.rdata;
    // Retry counters reaching the threshold on this retry
    genvar gi;
    generate
        for (gi = 0; gi < ENTRIES; gi++) begin : g_hit
            assign hit_limit[gi] = entry_retry[gi] && !entry_done[gi] &&
                                   (st_reg.cnt[gi] == LAST_RETRY);
        end
    endgenerate
    // Locked read timeout only counts while the locked read is outstanding
    assign lk_timeout_ev = lk_master_timeout && (st_reg.lk == BELC_LK_HOLD);
    // Raw system-error events before the disable bits and the timeout, forwarding and SERR enables
    always_comb begin
        ev_raw = '0;
        ev_raw[`BELC_EV_PW_PERR]   = pw_parity_reported && !pw_parity_self_detected
                                     && perr_pri && perr_sec;
        ev_raw[`BELC_EV_PW_TABORT] = pw_target_abort;
        ev_raw[`BELC_EV_PW_MABORT] = pw_master_abort &&
                                     st_reg.bctl[`BELC_BCTL_MA_MODE];
        ev_raw[`BELC_EV_MTIMEOUT]  = dt_master_timeout || lk_timeout_ev;
        ev_raw[`BELC_EV_SEC_SERR]  = !secondary_system_error_in_n;
        for (int i = 0; i < ENTRIES; i++) begin
            if (hit_limit[i]) begin
                case (belc_entry_kind_t'(entry_kind[2*i +: 2]))
                    BELC_ENT_POSTED: ev_raw[`BELC_EV_PW_DISCARD] = 1'b1;
                    BELC_ENT_DWRITE: ev_raw[`BELC_EV_DW_DISCARD] = 1'b1;
                    BELC_ENT_DREAD:  ev_raw[`BELC_EV_DR_GIVEUP]  = 1'b1;
                    default:         ev_raw[`BELC_EV_DR_GIVEUP]  = 1'b1;
                endcase
            end
        end
    end
    // Per-event gating: disable bits, except timeout and forwarding with their own enables
    always_comb begin
        ev_gate = ev_raw & ~st_reg.evdis;
        ev_gate[`BELC_EV_MTIMEOUT] = ev_raw[`BELC_EV_MTIMEOUT] &&
                                     st_reg.bctl[`BELC_BCTL_MTO_SERR];
        ev_gate[`BELC_EV_SEC_SERR] = ev_raw[`BELC_EV_SEC_SERR] &&
                                     st_reg.bctl[`BELC_BCTL_SERR_FWD];
    end
    assign serr_fire = serr_en && (|ev_gate);
    // Read mux for the register file
    always_comb begin
        rd_val = 32'h0000_0000;
        case (paddr)
            `BELC_OFF_CMD:   rd_val[15:0] = st_reg.cmd;
            `BELC_OFF_PSTS:  rd_val[`BELC_PSTS_SIG_SERR] = st_reg.sig_serr;
            `BELC_OFF_BCTL:  rd_val[15:0] = st_reg.bctl;
            `BELC_OFF_SSTS:  rd_val[`BELC_SSTS_RCV_SERR] = st_reg.rcv_serr;
            `BELC_OFF_EVDIS: rd_val[`BELC_EV_COUNT-1:0] = st_reg.evdis;
            `BELC_OFF_CAUSE: rd_val[`BELC_EV_COUNT-1:0] = st_reg.cause;
            `BELC_OFF_LOCK:  rd_val[2:0] = st_reg.lk;
            default:         rd_val = 32'h0000_0000;
        endcase
    end

    // Next-state logic for all block state
    always_comb begin
        st_next = st_reg;
        st_next.retry    = 1'b0;
        st_next.mabort   = 1'b0;
        st_next.queue    = 1'b0;
        st_next.sec_req  = 1'b0;
        st_next.ret_data = 1'b0;
        st_next.ret_ta   = 1'b0;
        st_next.ret_ma   = 1'b0;
        st_next.up_pass  = 1'b0;
        st_next.discard  = hit_limit;
        // Register writes; status bits are write-one-to-clear
        if (rd_setup) begin
            st_next.rdata = rd_val;
        end
        if (wr_acc) begin
            case (paddr)
                `BELC_OFF_CMD:   st_next.cmd   = pwdata[15:0];
                `BELC_OFF_BCTL:  st_next.bctl  = pwdata[15:0];
                `BELC_OFF_EVDIS: st_next.evdis = pwdata[`BELC_EV_COUNT-1:0];
                `BELC_OFF_PSTS:  if (pwdata[`BELC_PSTS_SIG_SERR]) st_next.sig_serr = 1'b0;
                `BELC_OFF_SSTS:  if (pwdata[`BELC_SSTS_RCV_SERR]) st_next.rcv_serr = 1'b0;
                `BELC_OFF_CAUSE: st_next.cause = st_reg.cause & ~pwdata[`BELC_EV_COUNT-1:0];
                default:         st_next.cmd   = st_reg.cmd;
            endcase
        end
        // Hardware sets come after the clears so a same-cycle event is kept
        if (serr_fire) begin
            st_next.sig_serr = 1'b1;
            st_next.cause = st_next.cause | ev_gate;
        end
        if (ev_gate[`BELC_EV_SEC_SERR]) begin
            st_next.rcv_serr = 1'b1;
        end
        // Parity-error pin: secondary role check or primary echo on upstream delayed write
        st_next.sperr = (((sec_target_write || sec_initiator_read) && sec_data_parity_err)
                         && perr_sec)
                     || (up_dwrite_completion && !primary_parity_error_n
                         && perr_pri && perr_sec);
        st_next.pserr = serr_fire;
        // Retry counters, one per queued entry; completion wins over a retry
        for (int i = 0; i < ENTRIES; i++) begin
            if (entry_done[i] || hit_limit[i]) begin
                st_next.cnt[i] = '0;
            end else if (entry_retry[i]) begin
                st_next.cnt[i] = st_reg.cnt[i] + CW'(1);
            end
        end
        // Upstream locked requests are forwarded as plain ones
        if (lk_first && lk_upstream) begin
            st_next.up_pass = 1'b1;
        end
        // Cross-bridge lock sequencer; idle leaves each bus lock to its own masters
        case (st_reg.lk)
            BELC_LK_IDLE: begin
                st_next.sec_lock_drv = 1'b0;
                if (lk_first && !lk_upstream) begin
                    if (sec_lock_other) begin
                        st_next.retry = 1'b1;
                    end else if (lk_cmd != `BELC_CMD_MEM_READ) begin
                        st_next.mabort = 1'b1;
                    end else begin
                        st_next.queue = 1'b1;
                        st_next.lk = BELC_LK_QUEUED;
                    end
                end
            end
            BELC_LK_QUEUED: begin
                // Earlier queued traffic drains first
                if (prior_queue_empty) begin
                    st_next.lk = BELC_LK_WAIT;
                end
            end
            BELC_LK_WAIT: begin
                // Another master holds the secondary lock: no bus request yet
                if (sec_lock_in_n && sec_bus_idle) begin
                    st_next.sec_req = 1'b1;
                    st_next.lk = BELC_LK_ISSUE;
                end
            end
            BELC_LK_ISSUE: begin
                // Lock stays released for the address phase, asserted one clock later
                st_next.sec_lock_drv = 1'b1;
                if (sec_read_ok) begin
                    st_next.lk = BELC_LK_HOLD;
                end else if (sec_read_tabort || sec_read_mabort) begin
                    st_next.sec_lock_drv  = 1'b0;
                    st_next.lk_aborted_ma = sec_read_mabort;
                    st_next.lk = BELC_LK_ABORT;
                end
            end
            BELC_LK_HOLD: begin
                if (lk_master_timeout) begin
                    st_next.sec_lock_drv = 1'b0;
                    st_next.lk = BELC_LK_IDLE;
                end else if (pri_repeat_match) begin
                    st_next.ret_data = 1'b1;
                    st_next.lk = BELC_LK_LOCKED;
                end
            end
            BELC_LK_ABORT: begin
                if (pri_repeat_match) begin
                    st_next.ret_ta = !st_reg.lk_aborted_ma;
                    st_next.ret_ma = st_reg.lk_aborted_ma;
                    st_next.lk = BELC_LK_IDLE;
                end
            end
            BELC_LK_LOCKED: begin
                if (lk_release) begin
                    st_next.sec_lock_drv = 1'b0;
                    st_next.lk = BELC_LK_IDLE;
                end
            end
            default: begin
                st_next.sec_lock_drv = 1'b0;
                st_next.lk = BELC_LK_IDLE;
            end
        endcase
        // Any new downstream initial lock while one crosses the bridge is retried
        if ((st_reg.lk != BELC_LK_IDLE) && lk_first && !lk_upstream) begin
            st_next.retry = 1'b1;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg       <= '0;
            st_reg.cmd   <= `BELC_RST_CMD;
            st_reg.bctl  <= `BELC_RST_BCTL;
            st_reg.evdis <= `BELC_RST_EVDIS;
            st_reg.lk    <= BELC_LK_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // Pins: both error pins only ever pull low, so the enable follows the assertion
    assign secondary_parity_error_n_o  = !st_reg.sperr;
    assign secondary_parity_error_oe_n = !st_reg.sperr;
    assign primary_system_error_n_o    = 1'b0;
    assign primary_system_error_oe_n   = !st_reg.pserr;
    assign entry_discard = st_reg.discard;
    assign sec_lock_out_n  = !st_reg.sec_lock_drv;
    assign lk_retry        = st_reg.retry;
    assign lk_master_abort = st_reg.mabort;
    assign lk_queue        = st_reg.queue;
    assign lk_sec_request  = st_reg.sec_req;
    assign lk_return_data   = st_reg.ret_data;
    assign lk_return_tabort = st_reg.ret_ta;
    assign lk_return_mabort = st_reg.ret_ma;
    assign lk_upstream_pass = st_reg.up_pass;
    // Posting stays allowed; only prefetch and new cross traffic are held off
    assign lk_no_prefetch    = (st_reg.lk != BELC_LK_IDLE);
    assign lk_cross_retry    = (st_reg.lk != BELC_LK_IDLE) &&
                               (st_reg.lk != BELC_LK_LOCKED);
    assign lk_forward_locked = (st_reg.lk == BELC_LK_LOCKED);

    // Checks
    a_serr_needs_en: assert property (@(posedge pclk) disable iff (!presetn)
        !primary_system_error_oe_n |-> $past(st_reg.cmd[`BELC_CMD_SERR_EN]))
        else $error("system error driven without enable");
    a_serr_sets_sts: assert property (@(posedge pclk) disable iff (!presetn)
        !primary_system_error_oe_n |-> st_reg.sig_serr)
        else $error("signaled status not set");
    a_sperr_cause: assert property (@(posedge pclk) disable iff (!presetn)
        !secondary_parity_error_oe_n |-> $past(perr_sec))
        else $error("parity pin without secondary response bit");
    a_fwd_sets_rcv: assert property (@(posedge pclk) disable iff (!presetn)
        (!secondary_system_error_in_n && st_reg.bctl[`BELC_BCTL_SERR_FWD])
        |=> st_reg.rcv_serr)
        else $error("received system error not recorded");
    a_disable_masks: assert property (@(posedge pclk) disable iff (!presetn)
        (st_reg.evdis[`BELC_EV_PW_TABORT] && pw_target_abort && !wr_acc)
        |=> !st_reg.cause[`BELC_EV_PW_TABORT] || $past(st_reg.cause[`BELC_EV_PW_TABORT]))
        else $error("disabled event recorded");
    a_first_memrd: assert property (@(posedge pclk) disable iff (!presetn)
        (st_reg.lk == BELC_LK_IDLE && lk_first && !lk_upstream && !sec_lock_other
         && lk_cmd != `BELC_CMD_MEM_READ) |=> lk_master_abort && st_reg.lk == BELC_LK_IDLE)
        else $error("non memory read first lock not aborted");
    a_lock_retry: assert property (@(posedge pclk) disable iff (!presetn)
        (st_reg.lk != BELC_LK_IDLE && lk_first && !lk_upstream) |=> lk_retry)
        else $error("second cross lock not retried");
    a_lock_one_late: assert property (@(posedge pclk) disable iff (!presetn)
        lk_sec_request |-> sec_lock_out_n ##1 (sec_lock_out_n || st_reg.lk == BELC_LK_ISSUE))
        else $error("lock asserted during address phase");
    a_wait_sec_lock: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(lk_sec_request) |-> $past(sec_lock_in_n) && $past(sec_bus_idle))
        else $error("request while secondary lock busy");
    a_timeout_drop: assert property (@(posedge pclk) disable iff (!presetn)
        (st_reg.lk == BELC_LK_HOLD && lk_master_timeout)
        |=> sec_lock_out_n && st_reg.lk == BELC_LK_IDLE)
        else $error("lock kept after timeout");
    a_up_no_lock: assert property (@(posedge pclk) disable iff (!presetn)
        (st_reg.lk == BELC_LK_IDLE && lk_first && lk_upstream)
        |=> lk_upstream_pass && st_reg.lk == BELC_LK_IDLE)
        else $error("upstream lock not passed plainly");
endmodule
`default_nettype wire

//--- testbench/belc_sec_target.sv
`default_nettype none
module belc_sec_target #(
    parameter int DLY = 3
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       lk_sec_request,
    input  wire logic       sec_lock_out_n,
    input  wire logic [1:0] abort,
    output logic            sec_read_ok,
    output logic            sec_read_tabort,
    output logic            sec_read_mabort
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    // Target ends the read only while the lock is held; no lock, no answer
    // Outcome select: 0 data, 1 target abort, 2 master abort
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            {sec_read_ok, sec_read_tabort, sec_read_mabort} <= 3'h0;
        end else begin
            {sec_read_ok, sec_read_tabort, sec_read_mabort} <= 3'h0;
            if (lk_sec_request) cnt <= DLY;
            else if (cnt > 1) cnt <= cnt - 1;
            else if (cnt == 1 && !sec_lock_out_n) begin
                cnt <= 0;
                sec_read_ok     <= (abort == 2'h0);
                sec_read_tabort <= (abort == 2'h1);
                sec_read_mabort <= (abort == 2'h2);
            end
        end
    end
endmodule
`default_nettype wire

//--- testbench/tb_bridge_error_and_lock_control.sv
`default_nettype none
module tb_bridge_error_and_lock_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, pready, pslverr, sl;
    logic [1:0] abort;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] entry_retry, entry_done, entry_discard, lk_cmd;
    logic [7:0] entry_kind;
    logic sec_data_parity_err, sec_target_write, sec_initiator_read, up_dwrite_completion;
    logic primary_parity_error_n, pw_parity_reported, pw_parity_self_detected, pw_target_abort;
    logic pw_master_abort, dt_master_timeout, secondary_system_error_in_n, lk_first, lk_upstream;
    logic sec_lock_other, sec_lock_in_n, sec_bus_idle, prior_queue_empty, pri_repeat_match;
    logic lk_master_timeout, lk_release, sec_read_ok, sec_read_tabort, sec_read_mabort;
    logic secondary_parity_error_n_o, secondary_parity_error_oe_n, primary_system_error_n_o;
    logic primary_system_error_oe_n, lk_retry, lk_master_abort, lk_queue, lk_sec_request;
    logic sec_lock_out_n, lk_return_data, lk_return_tabort, lk_return_mabort, lk_cross_retry;
    logic lk_no_prefetch, lk_forward_locked, lk_upstream_pass;
    int err_total = 0, n_checks = 0, cyc = 0;
    belc_error_lock #(.RETRY_LIMIT(4)) dut (.*);
    belc_sec_target sec (.*);
    always #5 pclk = ~pclk;
    task automatic conclude;
        if (err_total == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Hang guard, well above the whole sequence
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc > 3000) begin
            err_total++;
            conclude();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // APB: request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        sl = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    // One-cycle event on source k, then look one edge later
    task automatic go(input int k);
        for (int v = 1; v >= 0; v--) begin
            @(posedge pclk);
            case (k)
                0: pw_parity_reported <= v[0];
                1: pw_target_abort <= v[0];
                2: pw_master_abort <= v[0];
                3: lk_master_timeout <= v[0];
                4: entry_done[0] <= v[0];
                6: dt_master_timeout <= v[0];
                7: secondary_system_error_in_n <= !v[0];
                8: lk_first <= v[0];
                9: pri_repeat_match <= v[0];
                10: lk_release <= v[0];
                11: entry_retry[0] <= v[0];
                default: sec_data_parity_err <= v[0];
            endcase
        end
        #1;
    endtask
    task automatic ev(input int k, input logic e);
        go(k);
        chk({primary_system_error_n_o, primary_system_error_oe_n}, {1'b0, !e});
    endtask
    task automatic t_serr;
        int ks[5] = '{0, 1, 2, 6, 7};
        apb(0, 12'h000, '0);
        chk(q, 32'h0000_0000);
        apb(1, 12'h008, 32'h0000_0823);
        ev(7, 0);
        apb(1, 12'h000, 32'h0000_0102);
        foreach (ks[i]) begin
            ev(ks[i], 1);
            apb(0, 12'h014, '0);
            chk(q, 32'h1 << ks[i]);
            apb(1, 12'h014, q);
        end
        apb(0, 12'h004, '0);
        chk(q[30], 1);
        apb(0, 12'h00C, '0);
        chk(q[30], 1);
        apb(1, 12'h010, 32'h0000_00FF);
        ev(1, 0);
        ev(6, 1);
        apb(1, 12'h010, '0);
        apb(0, 12'h01C, '0);
        chk(sl, 1);
        @(posedge pclk) pw_parity_self_detected <= 1'b1;
        ev(0, 0);
    endtask
    task automatic t_perr;
        @(posedge pclk) sec_initiator_read <= 1'b1;
        go(12);
        chk({secondary_parity_error_n_o, secondary_parity_error_oe_n}, 0);
        @(posedge pclk) {sec_initiator_read, primary_parity_error_n} <= 2'h0;
        go(12);
        chk({secondary_parity_error_n_o, secondary_parity_error_oe_n}, 3);
        @(posedge pclk) up_dwrite_completion <= 1'b1;
        @(posedge pclk) up_dwrite_completion <= 1'b0;
        #1 chk({secondary_parity_error_n_o, secondary_parity_error_oe_n}, 0);
        repeat (3) go(11);
        chk(entry_discard, 0);
        go(11);
        chk(entry_discard, 4'h1);
        chk(primary_system_error_oe_n, 0);
        // Entry 0 now a delayed write; completion restarts its count
        @(posedge pclk) entry_kind <= 8'h01;
        repeat (3) go(11);
        go(4);
        go(11);
        chk(entry_discard, 0);
        repeat (3) go(11);
        chk({entry_discard, primary_system_error_oe_n}, 5'h02);
        apb(0, 12'h014, '0);
        chk(q, 32'h0000_0058);
    endtask
    task automatic t_lock;
        @(posedge pclk) lk_cmd <= 4'h2;
        go(8);
        chk(lk_master_abort, 1);
        @(posedge pclk) {lk_cmd, sec_lock_other} <= 5'h0D;
        go(8);
        chk(lk_retry, 1);
        @(posedge pclk) {sec_lock_other, lk_upstream} <= 2'h1;
        go(8);
        chk(lk_upstream_pass, 1);
        @(posedge pclk) {lk_upstream, sec_lock_in_n} <= 2'h0;
        go(8);
        chk(lk_queue, 1);
        repeat (6) @(posedge pclk);
        chk(sec_lock_out_n, 1);
        sec_lock_in_n <= 1'b1;
        for (int n = 0; n < 20 && lk_sec_request !== 1'b1; n++) begin
            @(posedge pclk);
            #1;
        end
        chk(lk_sec_request, 1);
        chk(sec_lock_out_n, 1);
        @(posedge pclk) #1 chk(sec_lock_out_n, 0);
        repeat (6) @(posedge pclk);
        chk(lk_no_prefetch, 1);
        go(9);
        chk({lk_return_data, lk_forward_locked, lk_cross_retry}, 3'h6);
        go(10);
        @(posedge pclk) abort <= 2'h1;
        go(8);
        repeat (14) @(posedge pclk);
        go(9);
        chk({lk_return_tabort, lk_return_mabort, sec_lock_out_n}, 3'h5);
        @(posedge pclk) abort <= 2'h2;
        go(8);
        repeat (14) @(posedge pclk);
        go(9);
        chk({lk_return_tabort, lk_return_mabort, lk_cross_retry}, 3'h2);
        // Locked read held, then a second lock attempt and a timeout
        @(posedge pclk) abort <= 2'h0;
        go(8);
        repeat (10) @(posedge pclk);
        go(8);
        chk(lk_retry, 1);
        go(3);
        chk({sec_lock_out_n, primary_system_error_oe_n, lk_no_prefetch}, 3'h4);
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, entry_retry, entry_done, entry_kind, lk_cmd} = '0;
        {sec_data_parity_err, sec_target_write, sec_initiator_read, up_dwrite_completion} = '0;
        {pw_parity_reported, pw_parity_self_detected, pw_target_abort, pw_master_abort} = '0;
        {dt_master_timeout, lk_first, lk_upstream, sec_lock_other, pri_repeat_match} = '0;
        {lk_master_timeout, lk_release, abort} = '0;
        {primary_parity_error_n, secondary_system_error_in_n, sec_lock_in_n} = 3'h7;
        {sec_bus_idle, prior_queue_empty} = 2'h3;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_serr();
        t_perr();
        t_lock();
        conclude();
    end
endmodule
`default_nettype wire
